// >>> rtl/timer_prescaler_lowpower_wake.sv
// Purpose: Eight-bit down-counter with a seven-bit prescaler, four input
//          modes, request flag and mask, and stop/wait bus handling.
// Assumes: cyc_tick_i pulses once per falling edge of the cycle clock.
// Notes:   Assert por_i together with reset_i once after power-up.
`timescale 1ns/1ps

// What this block does
// - Eight-bit down-counter fed by seven-bit prescaler.
// - Flag sets at zero or by writing one.
// - Unmasked flag interrupts; wait selects other vector.
// - Power-on reset loads count with FF.
// - Prescaler and counter advance on source falling edge.
// - Counts continuously, wraps 00 to FF.
// - Reading count never disturbs counting.
// - Flag holds until software clears it.
// - Select code picks divide 1 to 128.
// - Writing bit 3 clears prescaler, reads zero.
// - Prescaler has no processor read or write.
// - Mode 00 counts cycle clock, pin ignored.
// - Pin enable alone gates clock with pin.
// - Source select alone blocks counting.
// - Both set: count external pin edges.
// - Cycle clock keeps feeding timer during wait.
// - Resets and stop clear flag, set mask.
// - Control bits 5..0 survive external reset.
// - Low power: strobes low, read high, bus input.
// - Stop kills timer request, exits on irq/reset.
// - Wait exits on external, timer irq, reset.
// - External first; later timer uses normal vector.
// - Request made on 01 to 00 transition.
// - Masked request stays pending until unmasked.
module timer_prescaler_lowpower_wake
	import timer_pkg::*;
(
	input  wire logic        mclk_i,
	input  wire logic        reset_i,
	input  wire logic        por_i,
	input  wire logic        cyc_tick_i,
	input  wire logic        timer_pin_i,
	input  wire logic        irq_n_i,
	input  wire reg_req_t    reg_req_i,
	output logic [7:0]       rd_data_o,
	input  wire logic        cpu_imask_i,
	input  wire logic        timer_ack_i,
	input  wire logic        stop_enter_i,
	input  wire logic        wait_enter_i,
	output logic             timer_irq_o,
	output logic [12:0]      timer_vector_o,
	output logic             clear_imask_o,
	output logic             low_power_o,
	input  wire bus_pins_t   bus_pins_i,
	output logic             data_strobe_o,
	output logic             address_strobe_o,
	output logic             rw_o,
	output logic             mux_oe_n_o,
	output logic [4:0]       addr_hi_o
);

	// ==========================================================
	// Declarations
	// ==========================================================
	pwr_state_t  state_ff;
	pwr_state_t  nxt_state;
	logic [7:0]  count_ff;
	logic [6:0]  psc_ff;
	logic        req_ff;
	logic        mask_ff;
	logic        src_sel_ff;
	logic        pin_en_ff;
	logic [2:0]  psel_ff;
	logic [7:0]  rd_data_ff;
	logic [12:0] vec_ff;
	logic        wait_vec_ff;
	logic        pin_s1_ff;
	logic        pin_s2_ff;
	logic        pin_s3_ff;
	logic        irq_s1_ff;
	logic        irq_s2_ff;
	logic        ds_ff;
	logic        as_ff;
	logic        rw_ff;
	logic        oe_n_ff;
	logic [4:0]  addr_hi_ff;
	logic        clr_imask_ff;
	logic        any_reset;
	logic        ctrl_wr;
	logic        cnt_wr;
	logic        cnt_rd;
	logic        ctrl_rd;
	logic        int_tick;
	logic        pin_fall;
	logic        src_tick;
	logic        cnt_tick;
	logic        hw_set;
	logic        stop_go;
	logic        wait_go;
	logic        ext_irq;
	logic        timer_wake;
	logic        lp_next;

	// Returns true when the selected prescaler tap falls on this step.
	function automatic logic tap_fall(input logic [6:0] psc, input logic [2:0] sel);
		logic [6:0] low;
		low = 7'(PSC_FULL >> (3'd7 - sel));
		return (psc | ~low) == PSC_FULL;
	endfunction

	// Returns true when the access targets the given register.
	function automatic logic hit(input reg_req_t req, input logic [12:0] ofs);
		return req.addr == ofs;
	endfunction

	// ==========================================================
	// Decoding
	// ==========================================================
	// Register strobes and combined reset.
	assign any_reset = reset_i | por_i;
	assign ctrl_wr   = reg_req_i.wr & hit(reg_req_i, OFS_CONTROL);
	assign cnt_wr    = reg_req_i.wr & hit(reg_req_i, OFS_COUNT);
	assign ctrl_rd   = reg_req_i.rd & hit(reg_req_i, OFS_CONTROL);
	assign cnt_rd    = reg_req_i.rd & hit(reg_req_i, OFS_COUNT);
	assign ext_irq   = ~irq_s2_ff;
	assign stop_go   = stop_enter_i & (state_ff == PWR_RUN);
	assign wait_go   = wait_enter_i & (state_ff == PWR_RUN);

	// ==========================================================
	// Pin synchronisers
	// ==========================================================
	// Timer pin and interrupt pin pass two flops; a third gives edges.
	always_ff @(posedge mclk_i) begin
		if (any_reset) begin
			pin_s1_ff <= 1'b0;
			pin_s2_ff <= 1'b0;
			pin_s3_ff <= 1'b0;
			irq_s1_ff <= 1'b1;
			irq_s2_ff <= 1'b1;
		end else begin
			pin_s1_ff <= timer_pin_i;
			pin_s2_ff <= pin_s1_ff;
			pin_s3_ff <= pin_s2_ff;
			irq_s1_ff <= irq_n_i;
			irq_s2_ff <= irq_s1_ff;
		end
	end

	// ==========================================================
	// Count source selection
	// ==========================================================
	// The cycle clock keeps running in wait; only stop halts it.
	assign int_tick = cyc_tick_i & (state_ff != PWR_STOP);
	assign pin_fall = pin_s3_ff & ~pin_s2_ff;

	// Four input modes chosen by pin enable and source select.
	always_comb begin
		src_tick = 1'b0;
		unique case ({pin_en_ff, src_sel_ff})
			2'b00: src_tick = int_tick;
			2'b10: src_tick = int_tick & pin_s2_ff;
			2'b01: src_tick = 1'b0;
			2'b11: src_tick = pin_fall;
		endcase
	end

	// Counter steps when the chosen tap falls.
	assign cnt_tick = src_tick & tap_fall(psc_ff, psel_ff);
	assign hw_set   = cnt_tick & ~cnt_wr & (count_ff == CNT_ONE);

	// ==========================================================
	// Prescaler
	// ==========================================================
	// Free-running divider; processor can only clear it.
	always_ff @(posedge mclk_i) begin
		if (por_i) begin
			psc_ff <= PSC_ZERO;
		end else if (ctrl_wr & reg_req_i.wdata[BIT_PSC_CLR]) begin
			psc_ff <= PSC_ZERO;
		end else if (src_tick) begin
			psc_ff <= psc_ff + 7'h01;
		end
	end

	// ==========================================================
	// Counter
	// ==========================================================
	// A write replaces the count; otherwise it decrements and wraps.
	always_ff @(posedge mclk_i) begin
		if (por_i) begin
			count_ff <= RST_COUNT;
		end else if (cnt_wr) begin
			count_ff <= reg_req_i.wdata;
		end else if (cnt_tick) begin
			count_ff <= count_ff - 8'h01;
		end
	end

	// ==========================================================
	// Control register
	// ==========================================================
	// Request flag: hardware set beats a software clear.
	always_ff @(posedge mclk_i) begin
		if (any_reset | stop_go) begin
			req_ff <= 1'b0;
		end else if (hw_set) begin
			req_ff <= 1'b1;
		end else if (ctrl_wr) begin
			req_ff <= reg_req_i.wdata[BIT_REQ];
		end
	end

	// Interrupt mask bit.
	always_ff @(posedge mclk_i) begin
		if (any_reset | stop_go) begin
			mask_ff <= 1'b1;
		end else if (ctrl_wr) begin
			mask_ff <= reg_req_i.wdata[BIT_MASK];
		end
	end

	// Mode and prescaler select only clear on power-on.
	always_ff @(posedge mclk_i) begin
		if (por_i) begin
			src_sel_ff <= 1'b0;
			pin_en_ff  <= 1'b0;
			psel_ff    <= 3'h0;
		end else if (ctrl_wr) begin
			src_sel_ff <= reg_req_i.wdata[BIT_SRC];
			pin_en_ff  <= reg_req_i.wdata[BIT_PIN];
			psel_ff    <= reg_req_i.wdata[BIT_PSEL_HI:0];
		end
	end

	// Read data: clear bit reads zero, unmapped reads zero.
	always_ff @(posedge mclk_i) begin
		if (any_reset) begin
			rd_data_ff <= RD_ZERO;
		end else if (ctrl_rd) begin
			rd_data_ff <= {req_ff, mask_ff, src_sel_ff, pin_en_ff, 1'b0, psel_ff};
		end else if (cnt_rd) begin
			rd_data_ff <= count_ff;
		end else if (reg_req_i.rd) begin
			rd_data_ff <= RD_ZERO;
		end
	end

	// ==========================================================
	// Power state and wake-up
	// ==========================================================
	// Timer may wake the core only from wait, never from stop.
	assign timer_wake = req_ff & ~mask_ff & (state_ff == PWR_WAIT);

	always_comb begin
		nxt_state = state_ff;
		unique case (state_ff)
			PWR_RUN: begin
				if (stop_go) begin
					nxt_state = PWR_STOP;
				end else if (wait_go) begin
					nxt_state = PWR_WAIT;
				end
			end
			PWR_WAIT: begin
				if (ext_irq | timer_wake) begin
					nxt_state = PWR_RUN;
				end
			end
			PWR_STOP: begin
				if (ext_irq) begin
					nxt_state = PWR_RUN;
				end
			end
			default: nxt_state = PWR_RUN;
		endcase
	end

	always_ff @(posedge mclk_i) begin
		if (any_reset) begin
			state_ff <= PWR_RUN;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// Wait vector only when the timer alone ends the wait.
	always_ff @(posedge mclk_i) begin
		if (any_reset | timer_ack_i | ~req_ff) begin
			wait_vec_ff <= 1'b0;
		end else if (timer_wake & ~ext_irq) begin
			wait_vec_ff <= 1'b1;
		end else if (timer_wake) begin
			wait_vec_ff <= 1'b0;
		end
	end

	// Vector output registered from the wait marker.
	always_ff @(posedge mclk_i) begin
		if (any_reset) begin
			vec_ff <= VEC_TIMER;
		end else begin
			vec_ff <= wait_vec_ff ? VEC_WAIT : VEC_TIMER;
		end
	end

	// Request raised while unmasked; a masked one stays pending.
	assign timer_irq_o = req_ff & ~mask_ff & ~cpu_imask_i;

	// ==========================================================
	// Bus pins in low power
	// ==========================================================
	assign lp_next = (nxt_state != PWR_RUN);

	// Strobes low, read high, bus released, high address held.
	always_ff @(posedge mclk_i) begin
		if (any_reset) begin
			ds_ff        <= 1'b0;
			as_ff        <= 1'b0;
			rw_ff        <= 1'b1;
			oe_n_ff      <= 1'b1;
			addr_hi_ff   <= 5'h00;
			clr_imask_ff <= 1'b0;
		end else begin
			clr_imask_ff <= stop_go | wait_go;
			if (lp_next) begin
				ds_ff   <= 1'b0;
				as_ff   <= 1'b0;
				rw_ff   <= 1'b1;
				oe_n_ff <= 1'b1;
			end else begin
				ds_ff      <= bus_pins_i.ds;
				as_ff      <= bus_pins_i.as;
				rw_ff      <= bus_pins_i.rw;
				oe_n_ff    <= ~bus_pins_i.drive;
				addr_hi_ff <= bus_pins_i.addr_hi;
			end
		end
	end

	// ==========================================================
	// Outputs
	// ==========================================================
	assign rd_data_o        = rd_data_ff;
	assign timer_vector_o   = vec_ff;
	assign clear_imask_o    = clr_imask_ff;
	assign low_power_o      = (state_ff != PWR_RUN);
	assign data_strobe_o    = ds_ff;
	assign address_strobe_o = as_ff;
	assign rw_o             = rw_ff;
	assign mux_oe_n_o       = oe_n_ff;
	assign addr_hi_o        = addr_hi_ff;

	// ==========================================================
	// Assertions
	// ==========================================================
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (any_reset);

	sequence seq_tick_free;
		cnt_tick && !cnt_wr;
	endsequence

	sequence seq_hold_mode;
		pin_en_ff == 1'b0 && src_sel_ff == 1'b1 && !cnt_wr;
	endsequence

	AST_CNT_WRAP: assert property (seq_tick_free and count_ff == CNT_ZERO |=> count_ff == RST_COUNT)
		else $error("Counter did not wrap to FF.");
	AST_REQ_AT_ZERO: assert property (seq_tick_free and count_ff == CNT_ONE and !stop_go |=> req_ff)
		else $error("Flag not set at zero.");
	AST_READ_COUNT: assert property (cnt_rd |=> rd_data_o == $past(count_ff))
		else $error("Count read back wrong.");
	AST_PSC_CLEAR: assert property (ctrl_wr && reg_req_i.wdata[BIT_PSC_CLR] |=> psc_ff == PSC_ZERO)
		else $error("Prescaler not cleared.");
	AST_STOP_ENTRY: assert property (stop_go |=> !req_ff && mask_ff && low_power_o)
		else $error("Stop entry left timer armed.");
	AST_HOLD: assert property (seq_hold_mode |=> count_ff == $past(count_ff))
		else $error("Counter moved in hold mode.");
	AST_LP_PINS: assert property (low_power_o |-> !data_strobe_o && !address_strobe_o && rw_o && mux_oe_n_o)
		else $error("Bus pins wrong in low power.");
	AST_WAIT_VEC: assert property (timer_wake && !ext_irq && !timer_ack_i |=> ##1 timer_vector_o == VEC_WAIT)
		else $error("Wait vector not selected.");
	AST_LOAD: assert property (cnt_wr && !por_i |=> count_ff == $past(reg_req_i.wdata))
		else $error("Written count not loaded.");
	AST_IRQ: assert property (req_ff && cpu_imask_i && !ctrl_wr && !stop_go |=> req_ff)
		else $error("Masked request was not held pending.");

endmodule

// >>> rtl/timer_pkg.sv
// Purpose: Shared constants and types for the programmable timer block.
// Assumes: One system clock; register bus signals arrive on that clock.
// Notes:   Offsets are byte addresses on the internal processor bus.
package timer_pkg;

	// ==========================================================
	// Register map
	// ==========================================================
	localparam logic [12:0] OFS_COUNT   = 13'h0008;
	localparam logic [12:0] OFS_CONTROL = 13'h0009;

	// Control register field positions.
	localparam int BIT_REQ      = 7;
	localparam int BIT_MASK     = 6;
	localparam int BIT_SRC      = 5;
	localparam int BIT_PIN      = 4;
	localparam int BIT_PSC_CLR  = 3;
	localparam int BIT_PSEL_HI  = 2;

	// ==========================================================
	// Reset values and compare constants
	// ==========================================================
	localparam logic [7:0] RST_COUNT = 8'hFF;
	localparam logic [7:0] CNT_ONE   = 8'h01;
	localparam logic [7:0] CNT_ZERO  = 8'h00;
	localparam logic [6:0] PSC_ZERO  = 7'h00;
	localparam logic [6:0] PSC_FULL  = 7'h7F;
	localparam logic [7:0] RD_ZERO   = 8'h00;

	// ==========================================================
	// Interrupt vectors
	// ==========================================================
	localparam logic [12:0] VEC_TIMER = 13'h1FF8;
	localparam logic [12:0] VEC_WAIT  = 13'h1FF6;

	// ==========================================================
	// Types
	// ==========================================================
	// Power state of the processor as seen by the timer.
	typedef enum logic [2:0] {
		PWR_RUN  = 3'b001,
		PWR_WAIT = 3'b010,
		PWR_STOP = 3'b100
	} pwr_state_t;

	// One access of the processor to the register space.
	typedef struct packed {
		logic        rd;
		logic        wr;
		logic [12:0] addr;
		logic [7:0]  wdata;
	} reg_req_t;

	// Bus pin values the core wants to present while running.
	typedef struct packed {
		logic       ds;
		logic       as;
		logic       rw;
		logic       drive;
		logic [4:0] addr_hi;
	} bus_pins_t;

endpackage

// >>> test/core_model.sv
// Purpose: Processor core stand-in that makes cycle clock ticks and wanted bus pins.
// Assumes: One tick every five system clocks, as the oscillator divided by five.
// Notes:   Ticks come in counted bursts, so the bench knows how many were sent.
`timescale 1ns/1ps
module core_model
	import timer_pkg::*;
(
	input  wire logic        mclk_i,
	input  wire logic        reset_i,
	input  wire logic        go_i,
	input  wire logic [11:0] burst_i,
	output logic             cyc_tick_o,
	output logic             busy_o,
	output bus_pins_t        bus_pins_o
);
	// ==========================================================
	// Tick generator
	// ==========================================================
	logic [11:0] left_ff;
	logic [2:0]  div_ff;
	logic [7:0]  pat_ff;

	// Sends the requested ticks at one per five clocks, also during wait.
	always_ff @(posedge mclk_i) begin
		cyc_tick_o <= 1'b0;
		if (reset_i) begin
			left_ff <= 12'h000;
			div_ff <= 3'h0;
		end else if (go_i) begin
			left_ff <= burst_i;
			div_ff <= 3'h0;
		end else if (left_ff != 12'h000) begin
			div_ff <= (div_ff == 3'h4) ? 3'h0 : div_ff + 3'h1;
			if (div_ff == 3'h4) begin
				cyc_tick_o <= 1'b1;
				left_ff <= left_ff - 12'h001;
			end
		end
	end

	assign busy_o = (left_ff != 12'h000) | cyc_tick_o;

	// ==========================================================
	// Wanted bus pins
	// ==========================================================
	// A pattern that changes every cycle, so a held output cannot pass by luck.
	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			pat_ff <= 8'h00;
		end else begin
			pat_ff <= pat_ff + 8'h01;
		end
	end

	assign bus_pins_o = '{ds: pat_ff[0], as: pat_ff[0], rw: ~pat_ff[0], drive: pat_ff[1], addr_hi: pat_ff[6:2]};
endmodule

// >>> test/timer_prescaler_lowpower_wake_bench.sv
// Purpose: Self-checking bench for the timer with prescaler and low power modes.
// Assumes: Register accesses are single-cycle rd or wr pulses on the core bus.
// Notes:   Expected values follow from tick counts sent by the core model.
`timescale 1ns/1ps
module timer_prescaler_lowpower_wake_bench
	import timer_pkg::*;
;
	logic        mclk_i, reset_i, por_i, timer_pin_i, irq_n_i, cpu_imask_i;
	logic        timer_ack_i, stop_enter_i, wait_enter_i, go;
	logic        cyc_tick_i, busy, timer_irq_o, clear_imask_o, low_power_o;
	logic        data_strobe_o, address_strobe_o, rw_o, mux_oe_n_o;
	reg_req_t    reg_req_i;
	bus_pins_t   bus_pins_i;
	logic [11:0] nb;
	logic [7:0]  rd_data_o, d, c;
	logic [12:0] timer_vector_o;
	logic [4:0]  addr_hi_o, ah;
	int          n_fail, n_compared, i;

	timer_prescaler_lowpower_wake dut (.mclk_i, .reset_i, .por_i, .cyc_tick_i, .timer_pin_i, .irq_n_i,
		.reg_req_i, .rd_data_o, .cpu_imask_i, .timer_ack_i, .stop_enter_i, .wait_enter_i, .timer_irq_o,
		.timer_vector_o, .clear_imask_o, .low_power_o, .bus_pins_i, .data_strobe_o, .address_strobe_o,
		.rw_o, .mux_oe_n_o, .addr_hi_o);
	core_model partner (.mclk_i, .reset_i, .go_i(go), .burst_i(nb), .cyc_tick_o(cyc_tick_i), .busy_o(busy),
		.bus_pins_o(bus_pins_i));

	// ==========================================================
	// Clock and helpers
	// ==========================================================
	// Clock of 40 ns period.
	initial begin
		mclk_i = 1'b0;
		forever #20 mclk_i = ~mclk_i;
	end

	// Compares one value and reports a difference at once.
	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
		n_compared++;
		if (got !== exp) begin
			n_fail++;
			$display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	// One register write on the core bus.
	task automatic wr(input logic [12:0] a, input logic [7:0] v);
		@(posedge mclk_i);
		reg_req_i <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: v};
		@(posedge mclk_i);
		reg_req_i <= '0;
	endtask

	// One register read; data is registered on the sampling edge.
	task automatic rd(input logic [12:0] a, output logic [7:0] v);
		@(posedge mclk_i);
		reg_req_i <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
		@(posedge mclk_i);
		reg_req_i <= '0;
		#1 v = rd_data_o;
	endtask

	// Asks the core for n ticks, waits until they are sent and have landed.
	task automatic ticks(input logic [11:0] n);
		@(posedge mclk_i);
		nb <= n;
		go <= 1'b1;
		@(posedge mclk_i);
		go <= 1'b0;
		for (i = 0; i < 5000 && (busy !== 1'b0 || i == 0); i++) @(posedge mclk_i) #1;
		repeat (6) @(posedge mclk_i);
		#1;
	endtask

	// Prints the counts and the verdict, then ends the run.
	task automatic tally_and_finish();
		$display("compared %0d mismatches %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	// The tests take about 6000 clocks; this stops a hang well after that.
	initial begin
		#(60000 * 40);
		n_fail++;
		tally_and_finish();
	end

	// ==========================================================
	// Tests
	// ==========================================================
	// Main sequence of register calls and checks.
	initial begin
		n_fail = 0;
		n_compared = 0;
		reset_i = 1'b1;
		por_i = 1'b1;
		timer_pin_i = 1'b0;
		irq_n_i = 1'b1;
		cpu_imask_i = 1'b1;
		timer_ack_i = 1'b0;
		stop_enter_i = 1'b0;
		wait_enter_i = 1'b0;
		go = 1'b0;
		nb = 12'h000;
		reg_req_i = '0;
		repeat (4) @(posedge mclk_i);
		reset_i <= 1'b0;
		por_i <= 1'b0;
		rd(OFS_COUNT, d);
		chk(16'(d), 16'(RST_COUNT), "count after power-on");
		rd(OFS_CONTROL, d);
		chk(16'(d), 16'h0040, "control after power-on");
		rd(13'h000A, d);
		chk(16'(d), 16'h0000, "unmapped read");
		$display("test reset done");
		// Each tap gives four counts for four times its divide ratio.
		for (int s = 0; s < 8; s++) begin
			wr(OFS_CONTROL, 8'h48 | 8'(s));
			rd(OFS_CONTROL, d);
			chk(16'(d), 16'h0040 | 16'(s), "clear bit reads zero");
			wr(OFS_COUNT, 8'h10);
			ticks(12'(4 << s));
			rd(OFS_COUNT, d);
			chk(16'(d), 16'h000C, "four counts per tap");
		end
		$display("test prescaler done");
		wr(OFS_CONTROL, 8'h60);
		wr(OFS_COUNT, 8'h40);
		timer_pin_i <= 1'b1;
		ticks(8);
		rd(OFS_COUNT, d);
		chk(16'(d), 16'h0040, "blocked mode holds");
		wr(OFS_CONTROL, 8'h50);
		ticks(8);
		rd(OFS_COUNT, d);
		chk(16'(d), 16'h0038, "gated mode with pin high");
		timer_pin_i <= 1'b0;
		ticks(8);
		rd(OFS_COUNT, d);
		chk(16'(d), 16'h0038, "gated mode with pin low");
		wr(OFS_CONTROL, 8'h70);
		ticks(8);
		rd(OFS_COUNT, d);
		chk(16'(d), 16'h0038, "pin mode ignores cycle clock");
		repeat (5) begin
			@(posedge mclk_i);
			timer_pin_i <= 1'b1;
			repeat (4) @(posedge mclk_i);
			timer_pin_i <= 1'b0;
			repeat (4) @(posedge mclk_i);
		end
		repeat (6) @(posedge mclk_i);
		rd(OFS_COUNT, d);
		chk(16'(d), 16'h0033, "pin mode counts falling edges");
		$display("test modes done");
		wr(OFS_CONTROL, 8'h08);
		wr(OFS_COUNT, 8'h02);
		ticks(2);
		rd(OFS_CONTROL, d);
		chk(16'(d), 16'h0080, "flag at zero");
		chk(16'(timer_irq_o), 16'h0000, "held by cpu mask");
		cpu_imask_i <= 1'b0;
		@(posedge mclk_i) #1;
		chk(16'(timer_irq_o), 16'h0001, "raised once unmasked");
		chk(16'(timer_vector_o), 16'(VEC_TIMER), "normal vector");
		ticks(1);
		rd(OFS_COUNT, d);
		chk(16'(d), 16'h00FF, "wrap past zero");
		rd(OFS_CONTROL, d);
		chk(16'(d), 16'h0080, "flag stays set");
		wr(OFS_CONTROL, 8'h00);
		rd(OFS_CONTROL, d);
		chk(16'(d), 16'h0000, "flag cleared by write");
		chk(16'(timer_irq_o), 16'h0000, "request dropped");
		$display("test flag done");
		wr(OFS_COUNT, 8'h01);
		@(posedge mclk_i);
		wait_enter_i <= 1'b1;
		@(posedge mclk_i);
		wait_enter_i <= 1'b0;
		#1;
		chk(16'(low_power_o), 16'h0001, "wait entered");
		chk(16'({data_strobe_o, address_strobe_o, rw_o, mux_oe_n_o, clear_imask_o}), 16'h0007, "wait pins");
		ah = addr_hi_o;
		repeat (4) @(posedge mclk_i) #1;
		chk(16'(addr_hi_o), 16'(ah), "high address held");
		ticks(1);
		chk(16'(low_power_o), 16'h0000, "timer wakes wait");
		chk(16'(timer_vector_o), 16'(VEC_WAIT), "wait vector");
		@(posedge mclk_i);
		timer_ack_i <= 1'b1;
		@(posedge mclk_i);
		timer_ack_i <= 1'b0;
		repeat (2) @(posedge mclk_i) #1;
		chk(16'(timer_vector_o), 16'(VEC_TIMER), "normal vector after service");
		$display("test wait done");
		wr(OFS_CONTROL, 8'h80);
		rd(OFS_CONTROL, d);
		chk(16'(d), 16'h0080, "flag set by software");
		rd(OFS_COUNT, c);
		@(posedge mclk_i);
		stop_enter_i <= 1'b1;
		@(posedge mclk_i);
		stop_enter_i <= 1'b0;
		ticks(2);
		chk(16'(low_power_o), 16'h0001, "timer cannot end stop");
		irq_n_i <= 1'b0;
		for (i = 0; i < 10 && low_power_o !== 1'b0; i++) @(posedge mclk_i) #1;
		irq_n_i <= 1'b1;
		chk(16'(low_power_o), 16'h0000, "external interrupt ends stop");
		rd(OFS_CONTROL, d);
		chk(16'(d), 16'h0040, "stop drops request, masks");
		rd(OFS_COUNT, d);
		chk(16'(d), 16'(c), "no counting in stop");
		$display("test stop done");
		wr(OFS_CONTROL, 8'h35);
		wr(OFS_COUNT, 8'h77);
		@(posedge mclk_i);
		reset_i <= 1'b1;
		repeat (2) @(posedge mclk_i);
		reset_i <= 1'b0;
		rd(OFS_CONTROL, d);
		chk(16'(d), 16'h0075, "low bits survive reset");
		rd(OFS_COUNT, d);
		chk(16'(d), 16'h0077, "count survives reset");
		$display("test external reset done");
		tally_and_finish();
	end
endmodule
